//--- logic/sabg_top.sv
// Stack pointer monitor, bus master and bus slave protection with APB.
//
// Operation
// - Main and process stack pointers each checked for underflow and overflow.
// - A stack monitor checks only while its enable bit is one.
// - Start, end and action registers usable only while monitor enabled.
// - Lock bit blocks writes to control, start and end; reads still work.
// - Master addresses are compared over the full 32-bit space.
// - A protected access raises either a reset or an NMI request.
// - Each region has read and write permission, checked per access type.
// - Slave accesses to flash and SRAM are checked before they proceed.
// - Four requesters each have their own slave protection register.
// - Three groups, each with 32 regions, each with its own enable.
// - Region registers usable only after the group enable is set.
// - Region read and write protect act only while region enabled.
`timescale 1ns/1ps
module sabg_top #(
    parameter int NUM_REGIONS = 32
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU stack pointers.
    input wire logic [31:0] mainStackPointer,
    input wire logic [31:0] processStackPointer,
    // Bus master groups A to C.
    input wire logic [2:0] grpValid,
    input wire logic [2:0] grpWrite,
    input wire logic [31:0] grpAddr [3],
    // Slave requesters: CPU, A, B, C; target one is SRAM, zero flash.
    input wire logic [3:0] slvValid,
    input wire logic [3:0] slvWrite,
    input wire logic [3:0] slvTarget,
    output logic [3:0] slvGrant,
    // Responses.
    output logic resetReq,
    output logic nmiReq,
    output logic irq
);
    if (NUM_REGIONS < 1 || NUM_REGIONS > 32) begin : g_bad_regions
        $error("NUM_REGIONS must lie between 1 and 32");
    end

    localparam logic [5:0] NREG = 6'(NUM_REGIONS);
    localparam int G = sabg_pkg::NUM_GROUPS;

    logic [1:0] stkEn_reg, stkAct_reg, stkLock_reg;
    logic [31:0] stkStart_reg [2];
    logic [31:0] stkEnd_reg [2];
    logic [G-1:0] grpEn_reg, grpAct_reg;
    logic [2:0] rgnCtrl_reg [G][NUM_REGIONS];
    logic [31:0] rgnStart_reg [G][NUM_REGIONS];
    logic [31:0] rgnEnd_reg [G][NUM_REGIONS];
    logic [sabg_pkg::SLV_W-1:0] slvCtrl_reg [sabg_pkg::NUM_REQ];
    logic [7:0] status_reg, mask_reg;
    logic [31:0] prdata_next;
    logic err;

    // Address decode.
    logic stkIdx, stkHit, grpHit, slvHit, rgnHit, idxOk;
    logic [2:0] stkFld;
    logic [1:0] sel, rgnGrp, rgnFld;
    logic [4:0] rgnIdx;
    logic [11:0] rgnOff;
    logic setup, doWrite;
    assign stkIdx = paddr[11:5] == sabg_pkg::OFF_PROC_BASE[11:5];
    assign stkHit = stkIdx || paddr[11:5] == sabg_pkg::OFF_MAIN_BASE[11:5];
    assign stkFld = paddr[4:2];
    assign sel = paddr[3:2];
    assign grpHit = paddr[11:4] == sabg_pkg::OFF_GRP_CTRL[11:4]
        && 32'(sel) < G;
    assign slvHit = paddr[11:4] == sabg_pkg::OFF_SLAVE[11:4];
    assign rgnHit = paddr >= sabg_pkg::OFF_RGN_BASE
        && paddr < sabg_pkg::OFF_RGN_END;
    assign rgnOff = paddr - sabg_pkg::OFF_RGN_BASE;
    assign rgnGrp = rgnOff[10:9];
    assign rgnIdx = rgnOff[8:4];
    assign rgnFld = rgnOff[3:2];
    assign idxOk = {1'b0, rgnIdx} < NREG && rgnFld != 2'h3;
    assign setup = psel && !penable;
    assign doWrite = psel && penable && pwrite && !err;

    // Read data and error answer for the current address.
    always_comb begin
        prdata_next = '0;
        err = 1'b0;
        if (stkHit) begin
            case (stkFld)
                sabg_pkg::STK_CTRL: begin
                    prdata_next[sabg_pkg::BIT_EN] = stkEn_reg[stkIdx];
                    err = pwrite && stkLock_reg[stkIdx];
                end
                sabg_pkg::STK_START: begin
                    prdata_next = stkStart_reg[stkIdx];
                    err = !stkEn_reg[stkIdx]
                        || (pwrite && stkLock_reg[stkIdx]);
                end
                sabg_pkg::STK_END: begin
                    prdata_next = stkEnd_reg[stkIdx];
                    err = !stkEn_reg[stkIdx]
                        || (pwrite && stkLock_reg[stkIdx]);
                end
                sabg_pkg::STK_ACTION: begin
                    prdata_next[sabg_pkg::BIT_ACT_RESET] = stkAct_reg[stkIdx];
                    err = !stkEn_reg[stkIdx];
                end
                sabg_pkg::STK_LOCK:
                    prdata_next[sabg_pkg::BIT_LOCK] = stkLock_reg[stkIdx];
                default: err = 1'b1;
            endcase
        end else if (grpHit) begin
            prdata_next[sabg_pkg::BIT_EN] = grpEn_reg[sel];
            prdata_next[sabg_pkg::GRP_BIT_ACT] = grpAct_reg[sel];
        end else if (paddr == sabg_pkg::OFF_STATUS) begin
            prdata_next[7:0] = status_reg;
        end else if (paddr == sabg_pkg::OFF_MASK) begin
            prdata_next[7:0] = mask_reg;
        end else if (slvHit) begin
            prdata_next[sabg_pkg::SLV_W-1:0] = slvCtrl_reg[sel];
        end else if (rgnHit && idxOk && grpEn_reg[rgnGrp]) begin
            if (rgnFld == sabg_pkg::RGN_CTRL) begin
                prdata_next[2:0] = rgnCtrl_reg[rgnGrp][rgnIdx];
            end else if (rgnFld == sabg_pkg::RGN_START) begin
                prdata_next = rgnStart_reg[rgnGrp][rgnIdx];
            end else begin
                prdata_next = rgnEnd_reg[rgnGrp][rgnIdx];
            end
        end else begin
            err = 1'b1;
        end
    end

    // Zero-wait APB answer prepared during the setup cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= sabg_pkg::RST_WORD;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            prdata <= setup && !pwrite ? prdata_next : sabg_pkg::RST_WORD;
            pslverr <= setup && err;
        end
    end

    // Stack monitor registers; the lock can only be cleared by reset.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stkEn_reg <= '0;
            stkAct_reg <= '0;
            stkLock_reg <= '0;
            for (int i = 0; i < 2; i++) begin
                stkStart_reg[i] <= sabg_pkg::RST_WORD;
                stkEnd_reg[i] <= sabg_pkg::RST_TOP;
            end
        end else if (doWrite && stkHit) begin
            case (stkFld)
                sabg_pkg::STK_CTRL:
                    stkEn_reg[stkIdx] <= pwdata[sabg_pkg::BIT_EN];
                sabg_pkg::STK_START: stkStart_reg[stkIdx] <= pwdata;
                sabg_pkg::STK_END: stkEnd_reg[stkIdx] <= pwdata;
                sabg_pkg::STK_ACTION:
                    stkAct_reg[stkIdx] <= pwdata[sabg_pkg::BIT_ACT_RESET];
                sabg_pkg::STK_LOCK:
                    stkLock_reg[stkIdx] <= stkLock_reg[stkIdx]
                        | pwdata[sabg_pkg::BIT_LOCK];
                default: ;
            endcase
        end
    end

    // Group control, slave protection and interrupt mask registers.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            grpEn_reg <= '0;
            grpAct_reg <= '0;
            mask_reg <= '0;
            for (int r = 0; r < sabg_pkg::NUM_REQ; r++) begin
                slvCtrl_reg[r] <= '0;
            end
        end else if (doWrite) begin
            if (grpHit) begin
                grpEn_reg[sel] <= pwdata[sabg_pkg::BIT_EN];
                grpAct_reg[sel] <= pwdata[sabg_pkg::GRP_BIT_ACT];
            end
            if (slvHit) begin
                slvCtrl_reg[sel] <= pwdata[sabg_pkg::SLV_W-1:0];
            end
            if (paddr == sabg_pkg::OFF_MASK) begin
                mask_reg <= pwdata[7:0];
            end
        end
    end

    // Region registers of the three master groups.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int g = 0; g < G; g++) begin
                for (int n = 0; n < NUM_REGIONS; n++) begin
                    rgnCtrl_reg[g][n] <= '0;
                    rgnStart_reg[g][n] <= sabg_pkg::RST_WORD;
                    rgnEnd_reg[g][n] <= sabg_pkg::RST_WORD;
                end
            end
        end else if (doWrite && rgnHit) begin
            if (rgnFld == sabg_pkg::RGN_CTRL) begin
                rgnCtrl_reg[rgnGrp][rgnIdx] <= pwdata[2:0];
            end else if (rgnFld == sabg_pkg::RGN_START) begin
                rgnStart_reg[rgnGrp][rgnIdx] <= pwdata;
            end else begin
                rgnEnd_reg[rgnGrp][rgnIdx] <= pwdata;
            end
        end
    end

    // Event detection.
    logic [7:0] evt, actRst;
    logic [NUM_REGIONS-1:0] hitVec [G];
    logic [3:0] slvDeny, slvAct;
    logic [31:0] sp [2];
    assign sp[0] = mainStackPointer;
    assign sp[1] = processStackPointer;

    // Stacks grow downward: below start is overflow, above end underflow.
    for (genvar i = 0; i < 2; i++) begin : g_stack
        assign evt[2*i] = stkEn_reg[i]
            && sp[i] < stkStart_reg[i];
        assign evt[2*i+1] = stkEn_reg[i]
            && sp[i] > stkEnd_reg[i];
        assign actRst[2*i] = stkAct_reg[i];
        assign actRst[2*i+1] = stkAct_reg[i];
    end

    // Full 32-bit window compare per region, read and write kept apart.
    for (genvar g = 0; g < G; g++) begin : g_group
        for (genvar n = 0; n < NUM_REGIONS; n++) begin : g_region
            assign hitVec[g][n] = rgnCtrl_reg[g][n][sabg_pkg::BIT_EN]
                && grpAddr[g] >= rgnStart_reg[g][n]
                && grpAddr[g] <= rgnEnd_reg[g][n]
                && (grpWrite[g] ? rgnCtrl_reg[g][n][sabg_pkg::RGN_BIT_WP]
                    : rgnCtrl_reg[g][n][sabg_pkg::RGN_BIT_RP]);
        end
        assign evt[sabg_pkg::EVT_GRP0+g] = grpValid[g] && grpEn_reg[g]
            && |hitVec[g];
        assign actRst[sabg_pkg::EVT_GRP0+g] = grpAct_reg[g];
    end

    for (genvar r = 0; r < sabg_pkg::NUM_REQ; r++) begin : g_slave
        assign slvDeny[r] = slvValid[r] && (slvTarget[r]
            ? slvCtrl_reg[r][slvWrite[r] ? sabg_pkg::SLV_SRAM_WP
                : sabg_pkg::SLV_SRAM_RP]
            : slvCtrl_reg[r][slvWrite[r] ? sabg_pkg::SLV_FLASH_WP
                : sabg_pkg::SLV_FLASH_RP]);
        assign slvAct[r] = slvCtrl_reg[r][sabg_pkg::SLV_ACT];
    end
    assign evt[sabg_pkg::EVT_SLAVE] = |slvDeny;
    assign actRst[sabg_pkg::EVT_SLAVE] = 1'b0;

    // Grant is registered so a denied access never reaches the slave.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            slvGrant <= '0;
        end else begin
            slvGrant <= slvValid & ~slvDeny;
        end
    end

    // Responses; an event in the clearing cycle wins over the clear.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= '0;
            resetReq <= 1'b0;
            nmiReq <= 1'b0;
            irq <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~(doWrite
                && paddr == sabg_pkg::OFF_STATUS ? pwdata[7:0] : 8'h00))
                | evt;
            resetReq <= |(evt & actRst) || |(slvDeny & slvAct);
            nmiReq <= |(evt & ~actRst & ~sabg_pkg::EVT_SLAVE_MASK)
                || |(slvDeny & ~slvAct);
            irq <= |(status_reg & mask_reg);
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence grpAHit;
        grpValid[0] && grpEn_reg[0] && |hitVec[0];
    endsequence

    chk_main_overflow: assert property (
        stkEn_reg[0] && mainStackPointer < stkStart_reg[0]
        |=> status_reg[sabg_pkg::EVT_MAIN_OVER])
        else $error("Main stack overflow not flagged.");
    chk_monitor_off: assert property (
        !stkEn_reg[1] |=> !$rose(status_reg[sabg_pkg::EVT_PROC_OVER])
        && !$rose(status_reg[sabg_pkg::EVT_PROC_UNDER]))
        else $error("Disabled monitor raised an event.");
    chk_avail_error: assert property (
        setup && stkHit && stkFld == sabg_pkg::STK_START
        && !stkEn_reg[stkIdx] |=> pslverr)
        else $error("Start register usable while monitor off.");
    chk_lock_holds: assert property (
        stkLock_reg[0] && psel && penable && pwrite
        && paddr == sabg_pkg::OFF_MAIN_BASE |=> $stable(stkEn_reg[0]))
        else $error("Locked control register changed.");
    chk_group_action: assert property (
        grpAHit |=> status_reg[sabg_pkg::EVT_GRP0]
        && ($past(grpAct_reg[0]) ? resetReq : nmiReq))
        else $error("Group hit gave no response.");
    chk_group_gate: assert property (
        !grpEn_reg[2] |=> !$rose(status_reg[sabg_pkg::EVT_GRP0+2]))
        else $error("Disabled group raised an event.");
    chk_write_perm: assert property (
        grpValid[0] && grpEn_reg[0] && grpWrite[0]
        && rgnCtrl_reg[0][0][sabg_pkg::BIT_EN]
        && rgnCtrl_reg[0][0][sabg_pkg::RGN_BIT_WP]
        && grpAddr[0] >= rgnStart_reg[0][0]
        && grpAddr[0] <= rgnEnd_reg[0][0]
        |=> status_reg[sabg_pkg::EVT_GRP0])
        else $error("Protected write not flagged.");
    chk_slave_deny: assert property (
        slvDeny[1] |=> !slvGrant[1] && status_reg[sabg_pkg::EVT_SLAVE]
        ##1 (irq || !$past(mask_reg[sabg_pkg::EVT_SLAVE])))
        else $error("Denied slave access not blocked.");
endmodule

//--- logic/sabg_pkg.sv
// Shared constants of the stack and bus access guard.
package sabg_pkg;
    localparam int NUM_GROUPS = 3;
    localparam int NUM_REQ = 4;
    localparam int NUM_EVT = 8;
    localparam int SLV_W = 5;
    // Byte offsets on the register bus.
    localparam logic [11:0] OFF_MAIN_BASE = 12'h000;
    localparam logic [11:0] OFF_PROC_BASE = 12'h020;
    localparam logic [11:0] OFF_GRP_CTRL = 12'h040;
    localparam logic [11:0] OFF_STATUS = 12'h050;
    localparam logic [11:0] OFF_MASK = 12'h054;
    localparam logic [11:0] OFF_SLAVE = 12'h060;
    localparam logic [11:0] OFF_RGN_BASE = 12'h400;
    localparam logic [11:0] OFF_RGN_END = 12'hA00;
    // Word index inside one stack monitor block.
    localparam logic [2:0] STK_CTRL = 3'h0;
    localparam logic [2:0] STK_START = 3'h1;
    localparam logic [2:0] STK_END = 3'h2;
    localparam logic [2:0] STK_ACTION = 3'h3;
    localparam logic [2:0] STK_LOCK = 3'h4;
    // Word index inside one region slot of 16 bytes.
    localparam logic [1:0] RGN_CTRL = 2'h0;
    localparam logic [1:0] RGN_START = 2'h1;
    localparam logic [1:0] RGN_END = 2'h2;
    // Field positions.
    localparam int BIT_EN = 0;
    localparam int BIT_ACT_RESET = 0;
    localparam int BIT_LOCK = 0;
    localparam int GRP_BIT_ACT = 1;
    localparam int RGN_BIT_RP = 1;
    localparam int RGN_BIT_WP = 2;
    localparam int SLV_FLASH_RP = 0;
    localparam int SLV_FLASH_WP = 1;
    localparam int SLV_SRAM_RP = 2;
    localparam int SLV_SRAM_WP = 3;
    localparam int SLV_ACT = 4;
    // Status bit positions.
    localparam int EVT_MAIN_OVER = 0;
    localparam int EVT_MAIN_UNDER = 1;
    localparam int EVT_PROC_OVER = 2;
    localparam int EVT_PROC_UNDER = 3;
    localparam int EVT_GRP0 = 4;
    localparam int EVT_SLAVE = 7;
    localparam logic [7:0] EVT_SLAVE_MASK = 8'h80;
    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_TOP = 32'hFFFF_FFFF;
endpackage

//--- verification/sabg_masters.sv
// Bus master groups and slave requesters facing the guard.
`timescale 1ns/1ps
module sabg_masters (
    // Clock.
    input wire logic sys_clk,
    // Commands from the bench.
    input wire logic [2:0] cmdGrp,
    input wire logic cmdWrite,
    input wire logic [31:0] cmdAddr,
    input wire logic [3:0] cmdSlv,
    input wire logic cmdSram,
    // Requests towards the guard.
    output logic [2:0] grpValid,
    output logic [2:0] grpWrite,
    output logic [31:0] grpAddr [3],
    output logic [3:0] slvValid,
    output logic [3:0] slvWrite,
    output logic [3:0] slvTarget
);
    initial begin
        grpValid = 3'h0;
        grpWrite = 3'h0;
        grpAddr = '{default: 32'h0};
        {slvValid, slvWrite, slvTarget} = 12'h000;
    end
    // An idle master drops valid and inverts its other lines, so a stale address never looks valid.
    always @(posedge sys_clk) begin
        for (int g = 0; g < 3; g++) begin
            grpValid[g] <= cmdGrp[g];
            grpWrite[g] <= cmdGrp[g] ? cmdWrite : ~grpWrite[g];
            grpAddr[g] <= cmdGrp[g] ? cmdAddr : ~grpAddr[g];
        end
        slvValid <= cmdSlv;
        slvWrite <= (cmdSlv != 4'h0) ? {4{cmdWrite}} : ~slvWrite;
        slvTarget <= (cmdSlv != 4'h0) ? {4{cmdSram}} : ~slvTarget;
    end
endmodule

//--- verification/tb.sv
// Self-checking bench for the stack and bus access guard.
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] MB = sabg_pkg::OFF_MAIN_BASE;
    localparam logic [11:0] PB = sabg_pkg::OFF_PROC_BASE;
    localparam logic [11:0] MK = sabg_pkg::OFF_MASK;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, ra, ga;
    logic [31:0] pwdata, prdata, mainStackPointer, processStackPointer;
    logic [2:0] grpValid, grpWrite, cmdGrp;
    logic [31:0] grpAddr [3];
    logic [3:0] slvValid, slvWrite, slvTarget, slvGrant, cmdSlv;
    logic resetReq, nmiReq, irq, cmdWrite, cmdSram, err;
    logic [31:0] cmdAddr, rd, a;
    int n_errors = 0, n_tests = 0, nRst = 0, nNmi = 0;
    int expRst = 0, expNmi = 0, mStatus = 0, mMask = 0, seed;
    sabg_top sabg_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mainStackPointer(mainStackPointer),
        .processStackPointer(processStackPointer), .grpValid(grpValid),
        .grpWrite(grpWrite), .grpAddr(grpAddr), .slvValid(slvValid),
        .slvWrite(slvWrite), .slvTarget(slvTarget), .slvGrant(slvGrant),
        .resetReq(resetReq), .nmiReq(nmiReq), .irq(irq));
    sabg_masters sabg_masters_inst (.sys_clk(sys_clk), .cmdGrp(cmdGrp),
        .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdSlv(cmdSlv),
        .cmdSram(cmdSram), .grpValid(grpValid), .grpWrite(grpWrite),
        .grpAddr(grpAddr), .slvValid(slvValid), .slvWrite(slvWrite),
        .slvTarget(slvTarget));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Pulses are counted, so one event cycle must give exactly one pulse.
    always @(posedge sys_clk) begin
        nRst <= nRst + int'(resetReq === 1'b1);
        nNmi <= nNmi + int'(nmiReq === 1'b1);
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(logic [11:0] ad, logic [31:0] d, logic e);
        apb(1'b1, ad, d);
        check("wr_err", {31'h0, err}, {31'h0, e});
    endtask
    task automatic rdc(logic [11:0] ad, logic [31:0] d, logic e);
        apb(1'b0, ad, 32'h0);
        check("rd_err", {31'h0, err}, {31'h0, e});
        if (!e) check("rd_data", rd, d);
    endtask
    task automatic spk(logic proc, logic [31:0] v, logic hit, int b);
        if (proc) processStackPointer <= v;
        else mainStackPointer <= v;
        @(posedge sys_clk);
        mainStackPointer <= 32'h2000_1000;
        processStackPointer <= 32'h0000_0200;
        repeat (4) @(posedge sys_clk);
        if (hit) mStatus |= 1 << b;
    endtask
    task automatic grp(int g, logic w, logic [31:0] ad, logic hit, logic act);
        cmdGrp <= 3'(1 << g);
        cmdWrite <= w;
        cmdAddr <= ad;
        @(posedge sys_clk);
        cmdGrp <= 3'h0;
        repeat (4) @(posedge sys_clk);
        if (hit) mStatus |= 1 << (sabg_pkg::EVT_GRP0 + g);
        if (hit && act) expRst++;
        if (hit && !act) expNmi++;
    endtask
    task automatic slv(logic sram, logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        cmdSlv <= 4'hF;
        cmdWrite <= 1'b1;
        cmdSram <= sram;
        @(posedge sys_clk);
        cmdSlv <= 4'h0;
        repeat (4) begin
            @(posedge sys_clk);
            seen = seen | slvGrant;
        end
        check("grant", {28'h0, seen}, {28'h0, exp});
    endtask
    // Status, pulse counts and the interrupt level are compared to the model.
    task automatic sync(string name);
        apb(1'b0, sabg_pkg::OFF_STATUS, 32'h0);
        check("status", rd, 32'(mStatus));
        check("resets", 32'(nRst), 32'(expRst));
        check("nmis", 32'(nNmi), 32'(expNmi));
        check("irq", {31'h0, irq}, {31'h0, (mStatus & mMask) != 0});
        apb(1'b1, sabg_pkg::OFF_STATUS, 32'hFF);
        mStatus = 0;
        repeat (3) @(posedge sys_clk);
        check("irq_clr", {31'h0, irq}, 32'h0);
        $display("test %s done", name);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        complete_run();
    end
    initial begin
        seed = 32'ha42b762d;
        reset_n = 1'b0;
        {psel, penable, pwrite, cmdWrite, cmdSram} = 5'h00;
        {paddr, pwdata, cmdAddr} = 76'h0;
        {cmdGrp, cmdSlv} = 7'h00;
        mainStackPointer = 32'h2000_1000;
        processStackPointer = 32'h0000_0200;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rdc(MB, 32'h0, 1'b0);
        rdc(MB + 12'h008, 32'h0, 1'b1);
        rdc(12'hFFC, 32'h0, 1'b1);
        wr(MK, 32'hFF, 1'b0);
        mMask = 32'hFF;
        wr(MB, 32'h1, 1'b0);
        rdc(MB + 12'h008, 32'hFFFF_FFFF, 1'b0);
        wr(MB + 12'h004, 32'h2000_0000, 1'b0);
        wr(MB + 12'h008, 32'h2000_2000, 1'b0);
        wr(MB + 12'h00C, 32'h0, 1'b0);
        spk(1'b0, 32'h2000_0000, 1'b0, 0);
        spk(1'b0, 32'h2000_2000, 1'b0, 0);
        spk(1'b0, 32'h1FFF_FFFF, 1'b1, sabg_pkg::EVT_MAIN_OVER);
        spk(1'b0, 32'h2000_2001, 1'b1, sabg_pkg::EVT_MAIN_UNDER);
        spk(1'b1, 32'h0, 1'b0, 0);
        expNmi += 2;
        sync("main_stack");
        wr(MB + 12'h010, 32'h1, 1'b0);
        wr(MB + 12'h004, 32'h3000_0000, 1'b1);
        wr(MB, 32'h0, 1'b1);
        rdc(MB + 12'h004, 32'h2000_0000, 1'b0);
        rdc(MB, 32'h1, 1'b0);
        spk(1'b0, 32'h1FFF_FFFF, 1'b1, sabg_pkg::EVT_MAIN_OVER);
        expNmi++;
        wr(MK, 32'h1, 1'b0);
        mMask = 1;
        wr(PB, 32'h1, 1'b0);
        wr(PB + 12'h004, 32'h0000_0100, 1'b0);
        wr(PB + 12'h00C, 32'h1, 1'b0);
        spk(1'b1, 32'h0000_00FF, 1'b1, sabg_pkg::EVT_PROC_OVER);
        expRst++;
        sync("stack_lock");
        for (int g = 0; g < 3; g++) begin
            ra = sabg_pkg::OFF_RGN_BASE + 12'(g * 'h200 + (g > 0) * 'h1F0);
            ga = sabg_pkg::OFF_GRP_CTRL + 12'(g * 4);
            wr(ra, 32'h5, 1'b1);
            wr(ga, {30'h0, g == 1, 1'b1}, 1'b0);
            wr(ra + 12'h4, 32'hFFFF_F000, 1'b0);
            wr(ra + 12'h8, 32'hFFFF_FFFF, 1'b0);
            wr(ra, 32'h5, 1'b0);
            rdc(ra, 32'h5, 1'b0);
            a = 32'hFFFF_F000 | (32'($random(seed)) & 32'h0FFF);
            grp(g, 1'b0, a, 1'b0, 1'b0);
            grp(g, 1'b1, a, 1'b1, g == 1);
            grp(g, 1'b1, 32'hFFFF_FFFF, 1'b1, g == 1);
            grp(g, 1'b1, 32'hFFFF_EFFF, 1'b0, 1'b0);
            wr(ra, 32'h4, 1'b0);
            grp(g, 1'b1, a, 1'b0, 1'b0);
            sync("group");
        end
        wr(MK, 32'h80, 1'b0);
        mMask = 32'h80;
        wr(sabg_pkg::OFF_SLAVE + 12'h004, 32'h2, 1'b0);
        wr(sabg_pkg::OFF_SLAVE + 12'h00C, 32'h12, 1'b0);
        slv(1'b0, 4'b0101);
        slv(1'b1, 4'b1111);
        expRst++;
        expNmi++;
        mStatus |= 32'(sabg_pkg::EVT_SLAVE_MASK);
        sync("slave");
        complete_run();
    end
endmodule
